/* hdl/dbs_consts.svh */
// Constants for the dynamic bus sizing sequencer.
`ifndef DBS_CONSTS_SVH
`define DBS_CONSTS_SVH
`define DBS_SIZE_LONG  2'h0
`define DBS_SIZE_BYTE  2'h1
`define DBS_SIZE_WORD  2'h2
`define DBS_SIZE_THREE 2'h3
`define DBS_CNT_BYTE   3'h1
`define DBS_CNT_WORD   3'h2
`define DBS_CNT_LONG   3'h4
`define DBS_CNT_THREE  3'h3
`define DBS_CNT_ZERO   3'h0
`define DBS_OFS_MASK   2'h3
`define DBS_LANES_32   3'h4
`define DBS_LANES_16   3'h2
`define DBS_LANES_8    3'h1
`endif

/* hdl/dbs_pkg.sv */
// Types shared by the dynamic bus sizing sequencer.
package dbs_pkg;
	typedef enum logic [1:0]
	{
		DBS_OP_BYTE = 2'h1,
		DBS_OP_WORD = 2'h2,
		DBS_OP_LONG = 2'h0
	} dbs_opsize_t;

	typedef struct packed
	{
		logic        write;
		logic        fetch;
		dbs_opsize_t size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dbs_req_t;

	typedef struct packed
	{
		logic [31:0] addr;
		logic [1:0]  size_code;
		logic        write;
		logic [31:0] wdata;
	} dbs_bus_t;

	typedef enum logic [1:0]
	{
		DBS_ST_IDLE = 2'b00,
		DBS_ST_BUS  = 2'b01,
		DBS_ST_DONE = 2'b10
	} dbs_state_t;
endpackage

/* hdl/dbs_lane_mux.sv */
// Write lane router: places the remaining operand bytes onto the external data lanes.
`timescale 1ns/1ps
`include "dbs_consts.svh"
module dbs_lane_mux
(
	input  wire logic [31:0] operand,
	input  wire logic [2:0]  remaining,
	input  wire logic [1:0]  offset,
	output logic      [31:0] lanes
);
	import dbs_pkg::*;

	logic [7:0] op_byte [4];
	logic [1:0] first_idx;

	// Remaining bytes are the low-order end of the operand; byte k of them
	// must land on lane (offset+k), and a narrow port also sees them on its
	// upper lanes because byte lane n of the port is mirrored.
	always_comb
	begin
		lanes = 32'h0;
		for (int i = 0; i < 4; i++)
			op_byte[i] = operand[31 - 8*i -: 8];
		first_idx = 2'(3'h4 - remaining);
		for (int ln = 0; ln < 4; ln++)
		begin
			logic [1:0] k;
			logic [1:0] sel;
			k   = 2'(ln) - offset;
			sel = first_idx + k;
			lanes[31 - 8*ln -: 8] = op_byte[sel];
		end
		// Copies for narrow ports: lane 0 carries byte at offset, lanes 0/1
		// carry the halfword at offset, as a 16- or 8-bit port expects.
		// An odd offset is the second byte of a 16-bit port, even at offset three.
		lanes[31:24] = op_byte[first_idx];
		if (offset[0])
		begin
			lanes[23:16] = op_byte[first_idx];
		end
		else
		begin
			lanes[23:16] = (remaining > `DBS_CNT_BYTE) ? op_byte[2'(first_idx + 2'h1)]
			                                            : op_byte[first_idx];
		end
	end
endmodule

/* hdl/dbs_sequencer.sv */
// Dynamic bus sizing sequencer: splits operand accesses into sized bus cycles.
`timescale 1ns/1ps
`include "dbs_consts.svh"
module dbs_sequencer
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire dbs_pkg::dbs_req_t req,
	output logic                   done,
	output logic                   addr_error,
	output logic                   misaligned,
	output logic [31:0]            rdata,
	output logic [31:0]            fetch_hold,
	output logic                   fetch_hold_valid,
	output logic                   bus_start,
	output logic                   bus_active,
	output dbs_pkg::dbs_bus_t      bus,
	output logic                   remaining_size_bit0,
	output logic                   remaining_size_bit1,
	input  wire logic [31:0]       data_in,
	input  wire logic              ack_width_low,
	input  wire logic              ack_width_high
);
	import dbs_pkg::*;

	dbs_state_t  state_q,  state_d;
	logic [31:0] addr_q,   addr_d;
	logic [2:0]  rem_q,    rem_d;
	logic [31:0] op_q,     op_d;
	logic        write_q,  write_d;
	logic        fetch_q,  fetch_d;
	logic [31:0] rdata_q,  rdata_d;
	logic [31:0] hold_q,   hold_d;
	logic        hold_v_q, hold_v_d;
	logic        done_q,   done_d;
	logic        aerr_q,   aerr_d;
	logic        mis_q,    mis_d;
	logic        start_q,  start_d;
	logic [31:0] lanes;
	logic [1:0]  size_code;
	logic [2:0]  port_bytes;
	logic [2:0]  to_boundary;
	logic [2:0]  moved;
	logic        acked;
	logic [2:0]  req_cnt;

	dbs_lane_mux u_lane_mux
	(
		.operand   (op_q),
		.remaining (rem_q),
		.offset    (addr_q[1:0]),
		.lanes     (lanes)
	);

	// Size code reflects the bytes still owed, not what the port can take.
	always_comb
	begin
		unique case (rem_q)
			`DBS_CNT_BYTE: size_code = `DBS_SIZE_BYTE;
			`DBS_CNT_WORD: size_code = `DBS_SIZE_WORD;
			`DBS_CNT_THREE: size_code = `DBS_SIZE_THREE;
			default:       size_code = `DBS_SIZE_LONG;
		endcase
	end

	// Port width decoded from the acknowledge pair; none asserted is a wait state.
	always_comb
	begin
		acked      = ack_width_low | ack_width_high;
		port_bytes = `DBS_LANES_32;
		if (ack_width_high && !ack_width_low)
			port_bytes = `DBS_LANES_16;
		else if (ack_width_low && !ack_width_high)
			port_bytes = `DBS_LANES_8;
	end

	// Bytes moved are limited by port width, by the port's own word boundary
	// and by what remains; this alone yields every cycle count.
	always_comb
	begin
		logic [2:0] pos;
		pos         = {1'b0, addr_q[1:0]} & {1'b0, 2'(port_bytes - 3'h1)};
		to_boundary = 3'(port_bytes - pos);
		moved       = (to_boundary < rem_q) ? to_boundary : rem_q;
	end

	always_comb
	begin
		unique case (req.size)
			DBS_OP_BYTE: req_cnt = `DBS_CNT_BYTE;
			DBS_OP_WORD: req_cnt = `DBS_CNT_WORD;
			default:     req_cnt = `DBS_CNT_LONG;
		endcase
	end

	assign req_ready           = (state_q == DBS_ST_IDLE);
	assign bus_active          = (state_q == DBS_ST_BUS);
	assign bus_start           = start_q;
	assign done                = done_q;
	assign addr_error          = aerr_q;
	assign misaligned          = mis_q;
	assign rdata               = rdata_q;
	assign fetch_hold          = hold_q;
	assign fetch_hold_valid    = hold_v_q;
	assign remaining_size_bit0 = size_code[0];
	assign remaining_size_bit1 = size_code[1];

	always_comb
	begin
		bus.addr      = addr_q;
		bus.size_code = size_code;
		bus.write     = write_q;
		bus.wdata     = lanes;
	end

	always_comb
	begin
		state_d  = state_q;
		addr_d   = addr_q;
		rem_d    = rem_q;
		op_d     = op_q;
		write_d  = write_q;
		fetch_d  = fetch_q;
		start_d  = 1'b0;
		unique case (state_q)
			DBS_ST_IDLE:
			begin
				if (req_valid)
				begin
					// An odd fetch stays off the bus.
					if (req.fetch && !req.addr[0])
					begin
						// Whole aligned long word regardless of which word is needed.
						addr_d   = {req.addr[31:2], 2'h0};
						rem_d    = `DBS_CNT_LONG;
						write_d  = 1'b0;
						fetch_d  = 1'b1;
						state_d  = DBS_ST_BUS;
						start_d  = 1'b1;
					end
					else if (!req.fetch)
					begin
						addr_d  = req.addr;
						rem_d   = req_cnt;
						op_d    = req.wdata;
						write_d = req.write;
						fetch_d = 1'b0;
						state_d = DBS_ST_BUS;
						start_d = 1'b1;
					end
				end
			end
			DBS_ST_BUS:
			begin
				// Without an acknowledge every bus field holds as a wait state.
				if (acked)
				begin
					// Capture read bytes from the port's lanes into operand order.
					for (int k = 0; k < 4; k++)
					begin
						logic [2:0] idx;
						logic [1:0] lane;
						idx  = 3'(3'h4 - rem_q + 3'(k));
						lane = 2'((({1'b0, addr_q[1:0]} & {1'b0, 2'(port_bytes - 3'h1)}))
						       + 3'(k));
						if (!write_q && (3'(k) < moved))
							op_d[31 - 8*idx[1:0] -: 8] = data_in[31 - 8*lane -: 8];
					end
					// Advance by the bytes actually moved.
					rem_d  = 3'(rem_q - moved);
					addr_d = addr_q + {29'h0, moved};
					if (rem_q == moved)
						state_d = DBS_ST_DONE;
					else
						start_d = 1'b1;
				end
			end
			DBS_ST_DONE:
				state_d = DBS_ST_IDLE;
			default:
				state_d = DBS_ST_IDLE;
		endcase
	end

	// Status and results are a group of their own, so the pulses cannot be
	// disturbed by changes to the cycle sequencing.
	always_comb
	begin
		rdata_d = rdata_q;
		done_d  = 1'b0;
		aerr_d  = 1'b0;
		mis_d   = mis_q;
		if (req_ready && req_valid)
		begin
			if (req.fetch && req.addr[0])
			begin
				aerr_d = 1'b1;
				done_d = 1'b1;
			end
			else if (!req.fetch)
			begin
				// Misalignment only costs cycles, never an exception.
				mis_d = (req.size == DBS_OP_WORD && req.addr[0]) ||
				        (req.size == DBS_OP_LONG && (req.addr[1:0] != 2'h0));
			end
		end
		else if (state_q == DBS_ST_DONE)
		begin
			done_d  = 1'b1;
			rdata_d = op_q;
		end
	end

	// The holding register keeps the last fetched long word, both instruction words,
	// until the next even-addressed fetch clears its valid flag; each such fetch still runs its own bus cycles.
	always_comb
	begin
		hold_d   = hold_q;
		hold_v_d = hold_v_q;
		if (req_ready && req_valid && req.fetch && !req.addr[0])
		begin
			hold_v_d = 1'b0;
		end
		else if (state_q == DBS_ST_DONE && fetch_q)
		begin
			hold_d   = op_q;
			hold_v_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_q <= DBS_ST_IDLE;
			addr_q  <= 32'h0;
			rem_q   <= `DBS_CNT_ZERO;
			op_q    <= 32'h0;
			write_q <= 1'b0;
			fetch_q <= 1'b0;
			start_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			addr_q  <= addr_d;
			rem_q   <= rem_d;
			op_q    <= op_d;
			write_q <= write_d;
			fetch_q <= fetch_d;
			start_q <= start_d;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= 32'h0;
			done_q  <= 1'b0;
			aerr_q  <= 1'b0;
			mis_q   <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			done_q  <= done_d;
			aerr_q  <= aerr_d;
			mis_q   <= mis_d;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			hold_q   <= 32'h0;
			hold_v_q <= 1'b0;
		end
		else
		begin
			hold_q   <= hold_d;
			hold_v_q <= hold_v_d;
		end
	end
endmodule

/* sim/dbs_seq_sva.sv */
// Port-level checks for the bus sizing sequencer.
`timescale 1ns/1ps
module dbs_seq_sva
(
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              req_valid,
	input wire logic              req_ready,
	input wire dbs_pkg::dbs_req_t req,
	input wire logic              done,
	input wire logic              addr_error,
	input wire logic              bus_start,
	input wire logic              bus_active,
	input wire dbs_pkg::dbs_bus_t bus,
	input wire logic              remaining_size_bit0,
	input wire logic              remaining_size_bit1,
	input wire logic              ack_width_low,
	input wire logic              ack_width_high
);
	import dbs_pkg::*;
	logic take;
	logic ack;
	assign take = req_valid && req_ready;
	assign ack = bus_active && (ack_width_low || ack_width_high);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_size_pins:
	assert property (bus_active |-> {remaining_size_bit1, remaining_size_bit0} == bus.size_code)
		else $error("size pins wrong");
	a_first_cycle:
	assert property (take && !req.fetch |=> bus_start && bus.addr == $past(req.addr)
		&& bus.size_code == $past(req.size)) else $error("first cycle wrong");
	a_long_lanes:
	assert property (take && req.write && !req.fetch && req.size == DBS_OP_LONG
		&& req.addr[1:0] == 2'h0 |=> bus.wdata == $past(req.wdata)) else $error("lanes wrong");
	a_fetch_long:
	assert property (take && req.fetch && !req.addr[0] |=> bus_start && bus.size_code == 2'h0
		&& bus.addr == {$past(req.addr[31:2]), 2'h0}) else $error("fetch not long");
	a_odd_fetch:
	assert property (take && req.fetch && req.addr[0] |=> done && addr_error && !bus_active)
		else $error("odd fetch not trapped");
	a_no_trap:
	assert property (take && !req.fetch |=> !addr_error [*3]) else $error("data trap");
	a_wait_hold:
	assert property (bus_active && !ack |=> bus_active && $stable(bus)) else $error("no wait");
	a_word_after16:
	assert property (ack && !ack_width_low && bus.addr[1:0] == 2'h0 && bus.size_code == 2'h0
		|=> bus_start && bus.size_code == 2'h2 && bus.addr == $past(bus.addr) + 32'h2
		&& (!bus.write || bus.wdata[31:16] == $past(bus.wdata[15:0]))) else $error("no word");
	c_odd_fetch: cover property (take && req.fetch && req.addr[0]);
	c_word_port: cover property (ack && !ack_width_low && bus.size_code == 2'h0);
	c_waited: cover property (bus_active && !ack ##1 ack);
endmodule

bind dbs_sequencer dbs_seq_sva u_sva (.clk_sys, .rst, .req_valid, .req_ready, .req, .done,
	.addr_error, .bus_start, .bus_active, .bus, .remaining_size_bit0, .remaining_size_bit1,
	.ack_width_low, .ack_width_high);

/* sim/dbs_slave.sv */
// Sized slave port model with a small byte memory and selectable wait states.
`timescale 1ns/1ps
`include "dbs_consts.svh"
module dbs_slave
(
	input  wire logic              clk_sys,
	input  wire logic              bus_active,
	input  wire dbs_pkg::dbs_bus_t bus,
	input  wire logic [2:0]        w,
	input  wire logic [1:0]        lat,
	output logic [31:0]            data_in,
	output logic                   ack_width_low,
	output logic                   ack_width_high
);
	import dbs_pkg::*;
	logic [7:0] mem [16];
	logic [1:0] cnt = 2'h0;
	logic       tog = 1'b0;
	logic       ack;
	assign ack = bus_active && cnt >= lat;
	assign ack_width_low = ack && w != `DBS_LANES_16;
	assign ack_width_high = ack && w != `DBS_LANES_8;
	// Lanes outside the port, or outside an acked cycle, toggle so stale data cannot pass.
	always_comb
	begin
		int o;
		o = bus.addr % w;
		for (int k = 0; k < 4; k++)
			data_in[31 - 8 * k -: 8] = (ack && k < w) ? mem[(bus.addr - o + k) % 16] : {8{tog}};
	end
	always @(posedge clk_sys)
	begin
		int r;
		int o;
		int mv;
		tog <= ~tog;
		cnt <= (ack || !bus_active) ? 2'h0 : cnt + 2'h1;
		if (ack && bus.write)
		begin
			r = bus.size_code == 2'h0 ? 4 : bus.size_code;
			o = bus.addr % w;
			mv = r < w - o ? r : w - o;
			for (int k = 0; k < mv; k++)
				mem[(bus.addr + k) % 16] <= bus.wdata[31 - 8 * (o + k) -: 8];
		end
	end
endmodule

/* sim/dynamic_bus_sizing_sequencer_tb.sv */
// Self-checking bench for the bus sizing sequencer.
`timescale 1ns/1ps
module dynamic_bus_sizing_sequencer_tb;
	import dbs_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        req_valid = 1'b0;
	dbs_req_t    req = '0;
	logic [2:0]  w = 3'h4;
	logic [1:0]  lat = 2'h0;
	logic        req_ready, done, addr_error, misaligned, fetch_hold_valid, bus_start;
	logic        bus_active, ack_width_low, ack_width_high, sb0, sb1;
	logic [31:0] rdata, fetch_hold, data_in;
	dbs_bus_t    bus;
	int          fails = 0;
	int          total_checks = 0;
	int          n;
	// Nibbles: port bytes, size code, offset, bus cycles.
	logic [15:0] tab [20] = '{16'h4001, 16'h2002, 16'h1004, 16'h4012, 16'h2013, 16'h1014,
		16'h4022, 16'h2022, 16'h1024, 16'h4032, 16'h2033, 16'h1034, 16'h4232, 16'h2232,
		16'h1232, 16'h2212, 16'h1202, 16'h4111, 16'h2131, 16'h1121};
	always #12.5 clk_sys = ~clk_sys;
	dbs_sequencer DUT (.clk_sys, .rst, .req_valid, .req_ready, .req, .done, .addr_error,
		.misaligned, .rdata, .fetch_hold, .fetch_hold_valid, .bus_start, .bus_active, .bus,
		.remaining_size_bit0(sb0), .remaining_size_bit1(sb1), .data_in, .ack_width_low,
		.ack_width_high);
	dbs_slave u_slave (.clk_sys, .bus_active, .bus, .w, .lat, .data_in, .ack_width_low,
		.ack_width_high);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic wr, fe, input dbs_opsize_t sz, input logic [31:0] a, d);
		int t;
		t = 0;
		// Ready is read at a falling edge, where it has settled, before asking.
		while (req_ready !== 1'b1)
			@(negedge clk_sys);
		req <= '{wr, fe, sz, a, d};
		req_valid <= 1'b1;
		@(negedge clk_sys);
		req_valid <= 1'b0;
		n = bus_start;
		while (done !== 1'b1 && t < 200)
		begin
			@(negedge clk_sys);
			n += bus_start;
			t++;
		end
		chk("done pulse", 1'b1, done);
	endtask
	task automatic t_sizes();
		logic [31:0] d, m, a;
		logic        mis;
		dbs_opsize_t sz;
		for (int i = 0; i < 20; i++)
		begin
			sz = dbs_opsize_t'(tab[i][9:8]);
			m = sz == DBS_OP_BYTE ? 32'hFF : sz == DBS_OP_WORD ? 32'hFFFF : 32'hFFFFFFFF;
			mis = (sz == DBS_OP_WORD && tab[i][4]) || (sz == DBS_OP_LONG && tab[i][5:4] != 2'h0);
			d = 32'h10203040 + i * 32'h01010101;
			a = 32'h8 + tab[i][7:4];
			w <= tab[i][14:12];
			lat <= 2'(i % 3);
			xfer(1'b1, 1'b0, sz, a, d);
			chk("write cycles", tab[i][3:0], n);
			chk("misaligned", mis, misaligned);
			chk("no trap", 1'b0, addr_error);
			xfer(1'b0, 1'b0, sz, a, 32'h0);
			chk("read cycles", tab[i][3:0], n);
			chk("read data", d & m, rdata & m);
		end
		$display("t_sizes done");
	endtask
	task automatic t_fetch();
		for (int p = 1; p <= 4; p *= 2)
		begin
			w <= 3'(p);
			xfer(1'b1, 1'b0, DBS_OP_LONG, 32'h4, 32'h5A6B7C8D);
			xfer(1'b0, 1'b1, DBS_OP_WORD, 32'h6, 32'h0);
			chk("fetch cycles", 4 / p, n);
			chk("fetch hold", 32'h5A6B7C8D, fetch_hold);
			chk("hold valid", 1'b1, fetch_hold_valid);
		end
		$display("t_fetch done");
	endtask
	task automatic t_oddfetch();
		xfer(1'b0, 1'b1, DBS_OP_WORD, 32'h5, 32'h0);
		chk("odd fetch cycles", 0, n);
		chk("address error", 1'b1, addr_error);
		$display("t_oddfetch done");
	endtask
	task automatic close_out();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(negedge clk_sys);
		rst <= 1'b0;
		t_sizes();
		t_fetch();
		t_oddfetch();
		close_out();
	end
	// Some 50 operations of under 20 cycles each; 5000 cycles leaves ample margin.
	initial
	begin
		#125000;
		fails++;
		close_out();
	end
endmodule
